// ### hw/port_power_params.svh
// constants for the downstream port power control block
`ifndef PORT_POWER_PARAMS_SVH
`define PORT_POWER_PARAMS_SVH
`define CLK_MHZ 250
`define OC_FILTER_US 100
`define OC_FILTER_CYC ((`OC_FILTER_US * `CLK_MHZ))
`define VCONN_FILTER_US 10
`define VCONN_FILTER_CYC ((`VCONN_FILTER_US * `CLK_MHZ))
`define ADDR_CTRL 8'h00
`define ADDR_SPLIT 8'h04
`define ADDR_CHARGE 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_TYPEC_CFG 8'h10
`define ADDR_TYPEC_STAT 8'h14
`define CTRL_RESET 32'h0000_0000
`define TYPEC_CFG_RESET 32'h0000_0000
`define ADV_3A 2'h0
`define ADV_1A5 2'h1
`define ADV_DEFAULT 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hw/port_power_pkg.sv
// types for the downstream port power control block
package port_power_pkg;
    typedef enum logic [1:0] {ROLE_DFP, ROLE_UFP} role_e;
    typedef enum logic [1:0] {
        TC_IDLE, TC_ATTACHED, TC_VCONN_FAULT
    } typec_state_e;
endpackage

// ### hw/port_power_ctrl.sv
// downstream port power, over-current, split and type-c policy logic
`timescale 1ns/1ps
`default_nettype none
`include "port_power_params.svh"
// Contract
// - power off drives the port pin actively low.
// - pull-up is off while the pin is driven low.
// - power on releases the driver and enables the pull-up.
// - switch pulls pin low on fault; low while powered means over-current.
// - over-current input is filtered against short lows.
// - combined mode uses exactly one shared pin per port.
// - power is commanded by hub logic or by the processor.
// - every port starts in non-split mode after reset.
// - split off: one pin powers and senses both halves.
// - split on: primary pin for high-speed, second pin for superspeed.
// - split mode is set per port by one-time config or config bus.
// - a port pin can indicate an external charging supply.
// - DFP advertises 3A by default, configurable to 1.5A or default.
// - attach detection selects one of eight comparator thresholds.
// - UFP tracks partner's advertised current throughout the connection.
// - UFP applies Rd on both CC lines; VBUS starts the connection.
// - DFP with Ra present enables the VCONN FET by default.
// - VCONN on one CC pin only, chosen after attach by orientation.
// - VCONN pin below threshold flags fault and drops the FET enable.
// - UFP uses VBUS safe-5V/safe-0V to judge attach and detach.
module port_power_ctrl
    import port_power_pkg::*;
#(
    parameter int NPORT = 4,
    parameter int OC_FILTER_CYC = `OC_FILTER_CYC,
    parameter int VCONN_FILTER_CYC = `VCONN_FILTER_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [NPORT-1:0] HUB_POWER_ON,
    input wire logic [NPORT-1:0] OTP_SPLIT,
    input wire logic OTP_SPLIT_LOAD,
    input wire logic [NPORT-1:0] PORT_PIN_IN,
    output logic [NPORT-1:0] PORT_PIN_OUT,
    output logic [NPORT-1:0] PORT_PIN_OE,
    output logic [NPORT-1:0] PORT_PULLUP_EN,
    input wire logic [NPORT-1:0] SS_PIN_IN,
    output logic [NPORT-1:0] SS_PIN_OUT,
    output logic [NPORT-1:0] SS_PIN_OE,
    output logic [NPORT-1:0] SS_PULLUP_EN,
    output logic [NPORT-1:0] OVERCURRENT,
    input wire logic CC1_RD_SEEN,
    input wire logic CC2_RD_SEEN,
    input wire logic CC1_RA_SEEN,
    input wire logic CC2_RA_SEEN,
    input wire logic CC1_VCONN_LOW,
    input wire logic CC2_VCONN_LOW,
    input wire logic [1:0] PARTNER_ADV,
    input wire logic VBUS_SAFE5V,
    input wire logic VBUS_SAFE0V,
    output logic [1:0] CC_ADV_SEL,
    output logic [2:0] CC_THRESH_SEL,
    output logic CC_RD_EN,
    output logic VCONN_EN_A,
    output logic VCONN_EN_B,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    // synchronisers for every pin-side input
    logic [NPORT-1:0] pin_s1, pin_s2, ss_s1, ss_s2;
    logic [8:0] cc_s1, cc_s2;
    logic [1:0] adv_s1, adv_s2;
    logic [NPORT-1:0] cpu_power, cpu_sel, split, charge;
    logic [NPORT-1:0] oc_hs, oc_ss, power_hs, power_ss;
    logic [1:0] adv_cfg;
    logic [2:0] thresh_cfg;
    logic ufp_mode, vconn_allow;
    typec_state_e tc_state;
    logic vconn_on_b;
    logic [1:0] partner_adv_q;
    logic [7:0] aw_addr;
    logic aw_have, w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // cc/vbus comparator outputs come from the analog domain
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            ss_s1 <= '0;
            ss_s2 <= '0;
            cc_s1 <= '0;
            cc_s2 <= '0;
            adv_s1 <= '0;
            adv_s2 <= '0;
        end else begin
            pin_s1 <= PORT_PIN_IN;
            pin_s2 <= pin_s1;
            ss_s1 <= SS_PIN_IN;
            ss_s2 <= ss_s1;
            cc_s1 <= {VBUS_SAFE0V, VBUS_SAFE5V, CC2_VCONN_LOW, CC1_VCONN_LOW,
                      CC2_RA_SEEN, CC1_RA_SEEN, CC2_RD_SEEN, CC1_RD_SEEN,
                      1'b0};
            cc_s2 <= cc_s1;
            adv_s1 <= PARTNER_ADV;
            adv_s2 <= adv_s1;
        end
    end

    // per-port power request: hub logic or processor, per select bit
    logic [NPORT-1:0] want_power;
    assign want_power = (cpu_sel & cpu_power) |
                        (~cpu_sel & HUB_POWER_ON);

    // split off: ss half follows the primary half
    assign power_hs = want_power & ~oc_hs;
    // chosen bit by bit; a vector condition would switch all ports at once
    assign power_ss = (split & want_power & ~oc_ss) |
                      (~split & power_hs);

    // pin drive: off is a hard low, on is open drain with pull-up
    always_comb begin
        PORT_PIN_OUT = '0;
        PORT_PIN_OE = ~power_hs;
        // pull-up only while released, so a held-low pin wastes no current
        PORT_PULLUP_EN = power_hs;
        SS_PIN_OUT = '0;
        // unused ss pin is held low when not split
        SS_PIN_OE = ~(split & power_ss);
        SS_PULLUP_EN = split & power_ss;
    end

    // over-current filters: a low must persist for the whole window
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_oc
            logic [$clog2(OC_FILTER_CYC+1)-1:0] cnt_hs, cnt_ss;
            logic low_hs, low_ss;
            // low is only meaningful while powered, driver off
            assign low_hs = power_hs[g] & ~pin_s2[g] & ~charge[g];
            assign low_ss = split[g] & power_ss[g] & ~ss_s2[g];
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    cnt_hs <= '0;
                    oc_hs[g] <= 1'b0;
                end else begin
                    // restart on any high so ramp-up glitches vanish
                    if (!low_hs)
                        cnt_hs <= '0;
                    else if (cnt_hs != OC_FILTER_CYC[$bits(cnt_hs)-1:0])
                        cnt_hs <= cnt_hs + 1'b1;
                    // set wins over the re-enable clear
                    if (low_hs &&
                        cnt_hs == OC_FILTER_CYC[$bits(cnt_hs)-1:0] - 1'b1)
                        oc_hs[g] <= 1'b1;
                    else if (!want_power[g])
                        oc_hs[g] <= 1'b0;
                end
            end
            always_ff @(posedge CLK) begin
                if (!NRST) begin
                    cnt_ss <= '0;
                    oc_ss[g] <= 1'b0;
                end else begin
                    if (!low_ss)
                        cnt_ss <= '0;
                    else if (cnt_ss != OC_FILTER_CYC[$bits(cnt_ss)-1:0])
                        cnt_ss <= cnt_ss + 1'b1;
                    if (low_ss &&
                        cnt_ss == OC_FILTER_CYC[$bits(cnt_ss)-1:0] - 1'b1)
                        oc_ss[g] <= 1'b1;
                    else if (!want_power[g] || !split[g])
                        oc_ss[g] <= 1'b0;
                end
            end
        end
    endgenerate
    // a trip on either half shows on the port's one status flag
    assign OVERCURRENT = oc_hs | oc_ss;

    // type-c outputs straight from configuration
    assign CC_ADV_SEL = adv_cfg;
    assign CC_THRESH_SEL = thresh_cfg;
    assign CC_RD_EN = ufp_mode;

    // attach/vconn state: dfp by rd, ufp by vbus range
    logic attach_seen, detach_seen, vconn_low;
    always_comb begin
        if (ufp_mode) begin
            attach_seen = cc_s2[7];
            detach_seen = cc_s2[8];
        end else begin
            attach_seen = cc_s2[1] | cc_s2[2];
            detach_seen = ~(cc_s2[1] | cc_s2[2]);
        end
        // only the pin that carries the supply is watched
        vconn_low = vconn_on_b ? cc_s2[6] : cc_s2[5];
    end

    logic [$clog2(VCONN_FILTER_CYC+1)-1:0] vlow_cnt;
    logic vconn_active;
    assign vconn_active = (tc_state == TC_ATTACHED) && !ufp_mode &&
                          vconn_allow && (cc_s2[3] | cc_s2[4]);
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tc_state <= TC_IDLE;
            vconn_on_b <= 1'b0;
            vlow_cnt <= '0;
        end else begin
            case (tc_state)
                TC_IDLE: begin
                    if (attach_seen) begin
                        tc_state <= TC_ATTACHED;
                        // rd on cc1 means plug on cc1, supply goes to cc2
                        vconn_on_b <= cc_s2[1];
                    end
                end
                TC_ATTACHED: begin
                    if (detach_seen)
                        tc_state <= TC_IDLE;
                    else if (vconn_active && vlow_cnt ==
                             VCONN_FILTER_CYC[$bits(vlow_cnt)-1:0])
                        tc_state <= TC_VCONN_FAULT;
                end
                TC_VCONN_FAULT: begin
                    if (detach_seen)
                        tc_state <= TC_IDLE;
                end
                default: tc_state <= TC_IDLE;
            endcase
            // short dips while the fet turns on are ignored
            if (vconn_active && vconn_low)
                vlow_cnt <= vlow_cnt + 1'b1;
            else
                vlow_cnt <= '0;
        end
    end
    // one pin only, by construction
    assign VCONN_EN_A = vconn_active & ~vconn_on_b;
    assign VCONN_EN_B = vconn_active & vconn_on_b;

    // partner advertisement tracked for the whole connection
    always_ff @(posedge CLK) begin
        if (!NRST)
            partner_adv_q <= `ADV_DEFAULT;
        else if (ufp_mode && tc_state == TC_ATTACHED)
            partner_adv_q <= adv_s2;
    end

    // axi-lite write side: address and data in either order
    logic wr_fire;
    assign AWREADY = !aw_have && !BVALID;
    assign WREADY = !w_have && !BVALID;
    assign wr_fire = aw_have && w_have && !BVALID;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_have <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_have <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (aw_addr == `ADDR_STATUS ||
                          aw_addr == `ADDR_TYPEC_STAT ||
                          aw_addr > `ADDR_TYPEC_STAT) ?
                         `RESP_SLVERR : `RESP_OKAY;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // control registers; low byte lane only carries live fields
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cpu_power <= '0;
            cpu_sel <= '0;
            split <= '0;
            charge <= '0;
            adv_cfg <= `ADV_3A;
            thresh_cfg <= '0;
            ufp_mode <= 1'b0;
            vconn_allow <= 1'b1;
        end else begin
            // a bus write in the same cycle overrides the otp load
            if (OTP_SPLIT_LOAD)
                split <= OTP_SPLIT;
            if (wr_fire && w_strb[0]) begin
                case (aw_addr)
                    `ADDR_CTRL: begin
                        cpu_power <= w_data[NPORT-1:0];
                        cpu_sel <= w_data[NPORT+3:4];
                    end
                    `ADDR_SPLIT: split <= w_data[NPORT-1:0];
                    `ADDR_CHARGE: charge <= w_data[NPORT-1:0];
                    `ADDR_TYPEC_CFG: begin
                        adv_cfg <= w_data[1:0];
                        thresh_cfg <= w_data[4:2];
                        ufp_mode <= w_data[5];
                        vconn_allow <= ~w_data[6];
                    end
                    default: ;
                endcase
            end
        end
    end

    // read mux; charge indication keeps the pin pulled up without fault
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        case (a)
            `ADDR_CTRL: r = {24'h0, cpu_sel, cpu_power};
            `ADDR_SPLIT: r = {28'h0, split};
            `ADDR_CHARGE: r = {28'h0, charge};
            `ADDR_STATUS: r = {20'h0, oc_ss, oc_hs, power_ss & power_hs};
            `ADDR_TYPEC_CFG: r = {25'h0, ~vconn_allow, ufp_mode,
                                  thresh_cfg, adv_cfg};
            `ADDR_TYPEC_STAT: r = {24'h0, partner_adv_q, VCONN_EN_B,
                                   VCONN_EN_A, tc_state == TC_VCONN_FAULT,
                                   vconn_on_b, tc_state};
            default: r = '0;
        endcase
        return r;
    endfunction

    // axi-lite read side: one cycle to the answer
    assign ARREADY = !RVALID;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= `RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= read_word(ARADDR);
            // unmapped or unaligned reads answer with an error and zero data
            RRESP <= (ARADDR > `ADDR_TYPEC_STAT || ARADDR[1:0] != 2'h0) ?
                     `RESP_SLVERR : `RESP_OKAY;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### sim/power_switch_model.sv
// external power switch model driving one power/sense pin per port
`timescale 1ns/1ps
`default_nettype none
module power_switch_model #(
    parameter int NPORT = 4
) (
    input wire logic [NPORT-1:0] oe,
    input wire logic [NPORT-1:0] pu_en,
    input wire logic [NPORT-1:0] fault,
    output logic [NPORT-1:0] level
);
    // hub drive low wins; a tripped switch pulls the line low
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            if (oe[i])
                level[i] = 1'b0;
            else if (fault[i])
                level[i] = 1'b0;
            else
                level[i] = pu_en[i];
        end
    end
endmodule
`default_nettype wire

// ### sim/port_power_ctrl_assertions.sv
// assertion checker for the port power control block
`timescale 1ns/1ps
`default_nettype none
`include "port_power_params.svh"
module port_power_ctrl_assertions #(
    parameter int NPORT = 4,
    parameter int OC_FILTER_CYC = 8
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [NPORT-1:0] PORT_PIN_IN,
    input wire logic [NPORT-1:0] PORT_PIN_OUT,
    input wire logic [NPORT-1:0] PORT_PIN_OE,
    input wire logic [NPORT-1:0] PORT_PULLUP_EN,
    input wire logic [NPORT-1:0] SS_PIN_IN,
    input wire logic [NPORT-1:0] SS_PIN_OE,
    input wire logic [NPORT-1:0] SS_PULLUP_EN,
    input wire logic [NPORT-1:0] OVERCURRENT,
    input wire logic CC1_RD_SEEN,
    input wire logic CC2_RD_SEEN,
    input wire logic CC1_VCONN_LOW,
    input wire logic [1:0] CC_ADV_SEL,
    input wire logic VCONN_EN_A,
    input wire logic VCONN_EN_B,
    input wire logic BVALID,
    input wire logic BREADY
);
    int low_cnt;
    logic [2:0] rd_hist;
    // run of powered low samples on port 0; a lower bound on the filter
    always_ff @(posedge CLK) begin
        if (!NRST)
            low_cnt <= 0;
        else if ((!PORT_PIN_IN[0] && !PORT_PIN_OE[0]) ||
                (!SS_PIN_IN[0] && !SS_PIN_OE[0]))
            low_cnt <= low_cnt + 1;
        else
            low_cnt <= 0;
    end
    // recent attach samples, plug supply may only follow one
    always_ff @(posedge CLK) begin
        if (!NRST)
            rd_hist <= 3'h0;
        else
            rd_hist <= {rd_hist[1:0], CC1_RD_SEEN || CC2_RD_SEEN};
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    sequence short_a_s;
        (VCONN_EN_A && CC1_VCONN_LOW) [*4];
    endsequence
    sequence hs_trip_s;
        $rose(OVERCURRENT[0]) && !$past(SS_PULLUP_EN[0]);
    endsequence
    AST_PIN_LOW: assert property (PORT_PIN_OUT == '0)
        else $error("power pin driven high");
    AST_PU_EXCL: assert property ((PORT_PIN_OE ^ PORT_PULLUP_EN) == '1)
        else $error("pull-up and low drive not exclusive");
    AST_SS_EXCL: assert property ((SS_PIN_OE ^ SS_PULLUP_EN) == '1)
        else $error("ss pull-up and low drive not exclusive");
    AST_RESET: assert property (disable iff (1'b0) !NRST |=>
        PORT_PIN_OE == '1 && SS_PIN_OE == '1 && CC_ADV_SEL == `ADV_3A
        && !VCONN_EN_A && !VCONN_EN_B && OVERCURRENT == '0)
        else $error("wrong state after reset");
    AST_OC_FILTER: assert property ($rose(OVERCURRENT[0]) |->
        low_cnt >= OC_FILTER_CYC)
        else $error("over-current flagged before filter time");
    AST_OC_OFF: assert property (hs_trip_s |-> ##[0:2] PORT_PIN_OE[0])
        else $error("port not powered off on over-current");
    AST_OC_HOLD: assert property (OVERCURRENT[0] && PORT_PIN_OE[0] |=>
        PORT_PIN_OE[0] || !OVERCURRENT[0])
        else $error("power back on while over-current latched");
    AST_VCONN_ONE: assert property (!(VCONN_EN_A && VCONN_EN_B))
        else $error("plug supply on both pins");
    AST_VCONN_ATT: assert property ($rose(VCONN_EN_A || VCONN_EN_B) |->
        rd_hist != 3'h0)
        else $error("plug supply without attach");
    AST_VCONN_OC: assert property (short_a_s |-> ##[0:4] !VCONN_EN_A)
        else $error("plug supply kept on below threshold");
    AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write response dropped early");
    AST_B_DONE: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response kept after it was taken");
endmodule
bind port_power_ctrl port_power_ctrl_assertions #(
    .NPORT(NPORT),
    .OC_FILTER_CYC(OC_FILTER_CYC)
) chk_u (.CLK, .NRST, .PORT_PIN_IN, .PORT_PIN_OUT, .PORT_PIN_OE,
    .PORT_PULLUP_EN, .SS_PIN_IN, .SS_PIN_OE, .SS_PULLUP_EN, .OVERCURRENT,
    .CC1_RD_SEEN, .CC2_RD_SEEN, .CC1_VCONN_LOW, .CC_ADV_SEL, .VCONN_EN_A,
    .VCONN_EN_B, .BVALID, .BREADY);
`default_nettype wire

// ### sim/downstream_port_power_control_tb.sv
// self-checking bench for the port power control block
`timescale 1ns/1ps
`default_nettype none
`include "port_power_params.svh"
module downstream_port_power_control_tb import port_power_pkg::*;;
    localparam int OCF = 8;
    logic clk = 0, nrst = 0, otp_ld = 0, awvalid = 0, wvalid = 0;
    logic arvalid = 0, rd1 = 0, rd2 = 0, ra1 = 0, ra2 = 0, vl1 = 0;
    logic vl2 = 0, s5 = 0, s0 = 1;
    logic [3:0] hub_on = 0, otp_split = 0, hs_flt = 0, ss_flt = 0;
    logic [3:0] hs_in, hs_out, hs_oe, hs_pu, ss_in, ss_out, ss_oe, ss_pu, oc;
    logic [1:0] padv = 0, adv, bresp, rresp;
    logic [2:0] thr;
    logic rd_en, en_a, en_b, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    int errors = 0, cmp_count = 0;
    always #2 clk = ~clk;
    port_power_ctrl #(.OC_FILTER_CYC(OCF), .VCONN_FILTER_CYC(4)) dut_u (
        .CLK(clk), .NRST(nrst), .HUB_POWER_ON(hub_on), .OTP_SPLIT(otp_split),
        .OTP_SPLIT_LOAD(otp_ld), .PORT_PIN_IN(hs_in), .PORT_PIN_OUT(hs_out),
        .PORT_PIN_OE(hs_oe), .PORT_PULLUP_EN(hs_pu), .SS_PIN_IN(ss_in),
        .SS_PIN_OUT(ss_out), .SS_PIN_OE(ss_oe), .SS_PULLUP_EN(ss_pu),
        .OVERCURRENT(oc), .CC1_RD_SEEN(rd1), .CC2_RD_SEEN(rd2),
        .CC1_RA_SEEN(ra1), .CC2_RA_SEEN(ra2), .CC1_VCONN_LOW(vl1),
        .CC2_VCONN_LOW(vl2), .PARTNER_ADV(padv), .VBUS_SAFE5V(s5),
        .VBUS_SAFE0V(s0), .CC_ADV_SEL(adv), .CC_THRESH_SEL(thr),
        .CC_RD_EN(rd_en), .VCONN_EN_A(en_a), .VCONN_EN_B(en_b),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(1'b1));
    power_switch_model hs_sw_u (.oe(hs_oe), .pu_en(hs_pu), .fault(hs_flt),
        .level(hs_in));
    power_switch_model ss_sw_u (.oe(ss_oe), .pu_en(ss_pu), .fault(ss_flt),
        .level(ss_in));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", er, bresp);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er,
            logic [31:0] m = '1);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk("rdata", e, rdata & m);
        chk("rresp", er, rresp);
    endtask
    task automatic t_reset();
        chk("oe", 4'hF, hs_oe);
        chk("pullup", 4'h0, hs_pu);
        chk("pin out", 0, {hs_out, ss_out});
        chk("ss oe", 4'hF, ss_oe);
        chk("adv", `ADV_3A, adv);
        rd(`ADDR_SPLIT, 0, `RESP_OKAY);
        wr(8'h18, 32'h1, `RESP_SLVERR);
        wr(`ADDR_STATUS, 32'hFFF, `RESP_SLVERR);
        rd(8'h20, 0, `RESP_SLVERR);
        rd(`ADDR_STATUS, 0, `RESP_OKAY);
        $display("reset test done");
    endtask
    task automatic t_power();
        hub_on <= 4'h5;
        cyc(3);
        chk("oe on", 4'hA, hs_oe);
        chk("pu on", 4'h5, hs_pu);
        chk("one pin", 4'hF, ss_oe);
        wr(`ADDR_CTRL, 32'h0000_00A8, `RESP_OKAY);
        cyc(2);
        chk("cpu oe", 4'h2, hs_oe);
        rd(`ADDR_STATUS, 32'hD, `RESP_OKAY);
        wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
        hub_on <= 4'h0;
        cyc(3);
        chk("oe off", 4'hF, hs_oe);
        $display("power test done");
    endtask
    task automatic t_oc();
        hub_on <= 4'h1;
        cyc(3);
        hs_flt <= 4'h1;
        cyc(OCF - 2);
        hs_flt <= 4'h0;
        cyc(6);
        chk("glitch", 0, oc);
        hs_flt <= 4'h1;
        cyc(OCF + 6);
        hs_flt <= 4'h0;
        cyc(4);
        chk("oc", 4'h1, oc);
        chk("oc oe", 4'hF, hs_oe);
        rd(`ADDR_STATUS, 32'h10, `RESP_OKAY);
        hub_on <= 4'h0;
        cyc(3);
        chk("oc clr", 0, oc);
        wr(`ADDR_CHARGE, 32'h1, `RESP_OKAY);
        hub_on <= 4'h1;
        hs_flt <= 4'h1;
        cyc(OCF + 6);
        chk("chg oc", 0, oc);
        chk("chg pu", 4'h1, hs_pu);
        hs_flt <= 4'h0;
        hub_on <= 4'h0;
        wr(`ADDR_CHARGE, 32'h0, `RESP_OKAY);
        $display("over-current test done");
    endtask
    task automatic t_split();
        otp_split <= 4'h4;
        otp_ld <= 1'b1;
        @(posedge clk);
        otp_ld <= 1'b0;
        cyc(2);
        rd(`ADDR_SPLIT, 32'h4, `RESP_OKAY);
        wr(`ADDR_SPLIT, 32'h1, `RESP_OKAY);
        hub_on <= 4'h1;
        cyc(3);
        chk("ss on", 4'hE, ss_oe);
        ss_flt <= 4'h1;
        cyc(OCF + 6);
        chk("ss oc", 4'h1, oc);
        chk("ss off", 4'hF, ss_oe);
        chk("hs kept", 4'h1, hs_pu);
        ss_flt <= 4'h0;
        hub_on <= 4'h0;
        wr(`ADDR_SPLIT, 32'h0, `RESP_OKAY);
        cyc(3);
        chk("ss none", 4'hF, ss_oe);
        $display("split test done");
    endtask
    task automatic t_typec();
        for (int i = 0; i < 8; i++) begin
            wr(`ADDR_TYPEC_CFG, i * 4 + i % 3, `RESP_OKAY);
            chk("adv", i % 3, adv);
            chk("thr", i, thr);
        end
        wr(`ADDR_TYPEC_CFG, 32'h0, `RESP_OKAY);
        rd2 <= 1'b1;
        ra1 <= 1'b1;
        cyc(8);
        chk("vconn a", 2'b10, {en_a, en_b});
        vl1 <= 1'b1;
        cyc(12);
        chk("vconn oc", 2'b00, {en_a, en_b});
        rd(`ADDR_TYPEC_STAT, 32'h8, `RESP_OKAY, 32'h8);
        rd2 <= 1'b0;
        ra1 <= 1'b0;
        vl1 <= 1'b0;
        cyc(8);
        rd1 <= 1'b1;
        ra2 <= 1'b1;
        cyc(8);
        chk("vconn b", 2'b01, {en_a, en_b});
        rd1 <= 1'b0;
        ra2 <= 1'b0;
        wr(`ADDR_TYPEC_CFG, 32'h20, `RESP_OKAY);
        chk("rd en", 1, rd_en);
        padv <= 2'h1;
        s0 <= 1'b0;
        s5 <= 1'b1;
        cyc(8);
        rd(`ADDR_TYPEC_STAT, 32'h40 | TC_ATTACHED, `RESP_OKAY,
            32'hC3);
        padv <= 2'h2;
        cyc(8);
        rd(`ADDR_TYPEC_STAT, 32'h80, `RESP_OKAY, 32'hC0);
        s5 <= 1'b0;
        s0 <= 1'b1;
        cyc(8);
        rd(`ADDR_TYPEC_STAT, TC_IDLE, `RESP_OKAY, 32'h3);
        $display("type-c test done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #80000;
        errors++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        cyc(12);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_power();
        t_oc();
        t_split();
        t_typec();
        complete_run();
    end
endmodule
`default_nettype wire
